// File: inc/dma_channel_defs.svh
// Purpose: Offsets, field positions, reset values of one DMA channel
// Assumes: APB byte addresses, 32-bit data, one aligned word per register
// Notes: Included by the channel modules, the monitor and the testbench
`ifndef DMA_CHANNEL_DEFS_SVH
`define DMA_CHANNEL_DEFS_SVH

// ============================================================
// Register offsets
`define OFF_SIDE_A_COUNTER 8'h00
`define OFF_SIDE_B_COUNTER 8'h08
`define OFF_BLOCK_COUNTER 8'h10
`define OFF_CHANNEL_CONTROL 8'h1c
`define OFF_CHANNEL_STATUS 8'h20

// ============================================================
// Control field positions
`define BIT_CHANNEL_ON 0
`define BIT_BEAT_SIZE 3
`define BIT_TRANSFER_TYPE 4
`define BIT_DIRECTION 5
`define BIT_REPEAT_MODE 6
`define BIT_BUS_HOLD 7
`define BIT_SOFT_REQUEST 8
`define BIT_A_STEP_ENABLE 9
`define POS_A_STEP_CODE 10
`define BIT_B_STEP_ENABLE 12
`define POS_B_STEP_CODE 13
`define CONTROL_WIDTH 16
`define CONTROL_RESET 16'h0000
`define CONTROL_WRITE_MASK 16'h7fff

// ============================================================
// Status field positions
`define BIT_STAT_ACTIVE 0
`define BIT_STAT_BUS_OWNED 1
`define BIT_STAT_REQUEST 2

// ============================================================
// Counter widths and reset values
`define ADDR_WIDTH 32
`define COUNT_WIDTH 16
`define ADDR_RESET 32'h00000000
`define COUNT_RESET 16'h0000

`endif

// File: inc/dma_channel_pkg.sv
// Purpose: Types shared by the DMA channel modules
// Assumes: Constants come from dma_channel_defs.svh
// Notes: Types only
package dma_channel_pkg;

    // ============================================================
    // Transfer sequencer states
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_ARBITRATE,
        ST_READ,
        ST_WRITE,
        ST_RELEASE
    } seq_state_t;

    // ============================================================
    // Address step codes
    typedef enum logic [1:0] {
        STEP_INC1 = 2'b00,
        STEP_INC2 = 2'b01,
        STEP_DEC1 = 2'b10,
        STEP_DEC2 = 2'b11
    } step_code_t;

endpackage : dma_channel_pkg

// File: test/dma_channel_monitor.sv
// Purpose: Port assertions for one DMA channel
// Assumes: Control word is shadowed from accepted APB writes
// Notes: Bound to the channel module at the foot of this file
`timescale 1ns/10ps
`include "dma_channel_defs.svh"
module dma_channel_monitor (
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic pready,
    input wire logic flyByAck,
    input wire logic busRequest,
    input wire logic memRead,
    input wire logic memWrite,
    input wire logic memWordSize,
    input wire logic memDone,
    input wire logic channelClockOn
);
    // ============================================================
    // Shadow of the control word
    logic [15:0] ctl_reg;
    logic ctlWrite;
    assign ctlWrite = psel && penable && pwrite && pready && paddr == `OFF_CHANNEL_CONTROL;
    // Copy each accepted control write
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            ctl_reg <= `CONTROL_RESET;
        end else if (ctlWrite) begin
            ctl_reg <= pwdata[15:0] & `CONTROL_WRITE_MASK;
        end
    end

    // ============================================================
    // Assertions
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_b);
    a_flyby_read_dir: assert property (memRead && flyByAck |-> !ctl_reg[5])
        else $error("fly-by read with direction set");
    a_flyby_write_dir: assert property (memWrite && flyByAck |-> ctl_reg[5])
        else $error("fly-by write with direction clear");
    a_indirect_no_ack: assert property ((memRead || memWrite) |-> flyByAck == !ctl_reg[4])
        else $error("fly-by acknowledge does not match transfer type");
    a_beat_size_follow: assert property (memWordSize == ctl_reg[3])
        else $error("beat size differs from control");
    a_clock_on_follow: assert property (channelClockOn == ctl_reg[0])
        else $error("clock request differs from channel on");
    a_access_needs_on: assert property ((memRead || memWrite) |-> ctl_reg[0])
        else $error("bus access with channel off");
    a_release_after_done: assert property (memDone && !ctl_reg[7] && (flyByAck || memWrite)
        |=> !busRequest && !memRead && !memWrite)
        else $error("bus kept after transaction");
    a_request_needs_soft: assert property ($rose(busRequest) |-> ctl_reg[8])
        else $error("bus requested without soft request");
    a_access_held: assert property (memRead && !memDone |=> memRead [*1])
        else $error("read dropped before completion");
endmodule : dma_channel_monitor

bind dma_channel_control dma_channel_monitor mon (.clk_sys(clk_sys), .rst_b(rst_b),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pready(pready), .flyByAck(flyByAck), .busRequest(busRequest), .memRead(memRead),
    .memWrite(memWrite), .memWordSize(memWordSize), .memDone(memDone),
    .channelClockOn(channelClockOn));

// File: test/mem_partner_model.sv
// Purpose: Arbiter and memory behind the channel's bus master
// Assumes: One access at a time, done pulse lasts one cycle
// Notes: slow adds three cycles to grant and to each access
`timescale 1ns/10ps
module mem_partner_model (
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire logic slow,
    input wire logic busRequest,
    input wire logic memRead,
    input wire logic memWrite,
    input wire logic [31:0] memAddr,
    input wire logic [15:0] memWdata,
    output logic busGrant,
    output logic memDone,
    output logic [15:0] memRdata,
    output logic [15:0] lastWdata,
    output logic [15:0] readCount,
    output logic [15:0] writeCount,
    output logic [15:0] arbCount
);
    logic [3:0] gWait;
    logic [3:0] aWait;
    logic arbPrev;
    logic [3:0] lat;
    logic arbNow;
    assign lat = slow ? 4'h3 : 4'h0;
    assign arbNow = busRequest && !memRead && !memWrite;

    // ============================================================
    // Grant, completion and data; counts each kind of access
    always @(posedge clk_sys) begin
        if (!rst_b) begin
            {busGrant, memDone, gWait, aWait, arbPrev} <= '0;
            {memRdata, lastWdata, readCount, writeCount, arbCount} <= '0;
        end else begin
            arbPrev <= arbNow;
            if (arbNow && !arbPrev) arbCount <= arbCount + 16'h1;
            gWait <= (busRequest && !busGrant) ? gWait + 4'h1 : 4'h0;
            busGrant <= busRequest && (busGrant || gWait >= lat);
            if ((memRead || memWrite) && !memDone) begin
                aWait <= aWait + 4'h1;
                if (aWait >= lat) begin
                    memDone <= 1'b1;
                    aWait <= 4'h0;
                    memRdata <= memAddr[15:0] ^ 16'ha5a5;
                    if (memRead) readCount <= readCount + 16'h1;
                    if (memWrite) writeCount <= writeCount + 16'h1;
                    if (memWrite) lastWdata <= memWdata;
                end
            end else begin
                memDone <= 1'b0;
                aWait <= 4'h0;
                memRdata <= ~memRdata; // Released data never holds its last value
            end
        end
    end
endmodule : mem_partner_model

// File: test/tb.sv
// Purpose: Self-checking bench of one DMA channel over APB
// Assumes: Zero-wait APB slave, partner model on the bus side
// Notes: Hardware request pin stays low; soft request drives all traffic
`timescale 1ns/10ps
`include "dma_channel_defs.svh"
module tb;
    logic clk_sys = 1'b0;
    logic rst_b = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic hwRequest = 1'b0;
    logic slow = 1'b0;
    logic [31:0] prdata, rdData, rdErr;
    logic pready, pslverr, flyByAck, busRequest, busGrant, memRead, memWrite, memWordSize;
    logic memDone, channelClockOn;
    logic [31:0] memAddr;
    logic [15:0] memWdata, memRdata, lastWdata, readCount, writeCount, arbCount;
    logic [15:0] r0, w0, g0;
    int errCount = 0;
    int cmpCount = 0;
    int i;

    always #5 clk_sys = ~clk_sys;

    dma_channel_control uut (.clk_sys(clk_sys), .rst_b(rst_b), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .hwRequest(hwRequest),
        .flyByAck(flyByAck), .busRequest(busRequest), .busGrant(busGrant),
        .memAddr(memAddr), .memRead(memRead), .memWrite(memWrite),
        .memWordSize(memWordSize), .memWdata(memWdata), .memRdata(memRdata),
        .memDone(memDone), .channelClockOn(channelClockOn));

    mem_partner_model partner (.clk_sys(clk_sys), .rst_b(rst_b), .slow(slow),
        .busRequest(busRequest), .memRead(memRead), .memWrite(memWrite),
        .memAddr(memAddr), .memWdata(memWdata), .busGrant(busGrant), .memDone(memDone),
        .memRdata(memRdata), .lastWdata(lastWdata), .readCount(readCount),
        .writeCount(writeCount), .arbCount(arbCount));

    // ============================================================
    // Access, compare and closing tasks
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        do @(posedge clk_sys); while (pready !== 1'b1);
        rdData = prdata;
        rdErr = {31'h0, pslverr};
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        cmpCount++;
        if (seen !== exp) begin
            errCount++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask : chk

    task automatic conclude();
        if (errCount == 0 && cmpCount > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : conclude

    function automatic logic [31:0] stepOf(input logic [1:0] c);
        case (c)
            2'b00: return 32'h00000001;
            2'b01: return 32'h00000002;
            2'b10: return 32'hffffffff;
            default: return 32'hfffffffe;
        endcase
    endfunction : stepOf

    // Loads counters and control, starts by writing the count, waits for it to drain when the channel is on and not in auto-initialize
    task automatic run(input logic [31:0] a, b, input logic [15:0] c, n);
        int k;
        r0 = readCount;
        w0 = writeCount;
        g0 = arbCount;
        apb(1'b1, `OFF_SIDE_A_COUNTER, a);
        apb(1'b1, `OFF_SIDE_B_COUNTER, b);
        apb(1'b1, `OFF_CHANNEL_CONTROL, {16'h0, c});
        apb(1'b1, `OFF_BLOCK_COUNTER, {16'h0, n});
        k = 0;
        do begin
            apb(1'b0, `OFF_BLOCK_COUNTER, 32'h0);
            k++;
        end while (rdData !== 32'h0 && k < 100 && n != 16'h0 && c[0] && c[6] == 1'b0);
        if (k >= 100) errCount++;
    endtask : run

    // ============================================================
    // Main sequence
    initial begin
        repeat (10) @(posedge clk_sys);
        rst_b <= 1'b1;
        apb(1'b0, `OFF_CHANNEL_CONTROL, 32'h0);
        chk("control reset", rdData, 32'h0);
        apb(1'b1, `OFF_CHANNEL_CONTROL, 32'h0000ffff);
        apb(1'b0, `OFF_CHANNEL_CONTROL, 32'h0);
        chk("control mask", rdData, 32'h00007fff);
        apb(1'b0, 8'h04, 32'h0);
        chk("unmapped error", rdErr, 32'h1);
        apb(1'b1, `OFF_CHANNEL_CONTROL, 32'h0);
        // Fly-by in both directions, quick and slow partner
        for (i = 0; i < 2; i++) begin
            slow <= i[0];
            run(32'h100, 32'h0, 16'h0301 | 16'(i << 5), 16'h2);
            chk("fly-by reads", {16'h0, readCount - r0}, i ? 32'h0 : 32'h2);
            chk("fly-by writes", {16'h0, writeCount - w0}, i ? 32'h2 : 32'h0);
            chk("arbitrations", {16'h0, arbCount - g0}, 32'h2);
            apb(1'b0, `OFF_SIDE_A_COUNTER, 32'h0);
            chk("side a count", rdData, 32'h102);
        end
        // Indirect with every step code on both counters
        for (i = 0; i < 4; i++) begin
            run(32'h200, 32'h400, 16'h1319 | 16'(i << 10) | 16'((3 - i) << 13), 16'h1);
            apb(1'b0, `OFF_SIDE_A_COUNTER, 32'h0);
            chk("side a step", rdData, 32'h200 + stepOf(i[1:0]));
            apb(1'b0, `OFF_SIDE_B_COUNTER, 32'h0);
            chk("side b step", rdData, 32'h400 + stepOf(2'(3 - i)));
            chk("moved data", {16'h0, lastWdata}, 32'h0000a7a5);
            chk("indirect pair", {readCount - r0, writeCount - w0}, 32'h00010001);
        end
        // Burst with soft request and frozen counters
        run(32'h300, 32'h500, 16'h0191, 16'h3);
        apb(1'b0, `OFF_SIDE_A_COUNTER, 32'h0);
        chk("side a frozen", rdData, 32'h300);
        apb(1'b0, `OFF_SIDE_B_COUNTER, 32'h0);
        chk("side b frozen", rdData, 32'h500);
        chk("burst arbitrations", {16'h0, arbCount - g0}, 32'h1);
        chk("burst pairs", {readCount - r0, writeCount - w0}, 32'h00030003);
        // Auto-initialize keeps reloading until the request is withdrawn
        run(32'h100, 32'h0, 16'h0341, 16'h1);
        repeat (60) @(posedge clk_sys);
        apb(1'b1, `OFF_CHANNEL_CONTROL, 32'h00000041);
        repeat (20) @(posedge clk_sys);
        apb(1'b0, `OFF_BLOCK_COUNTER, 32'h0);
        chk("reloaded count", rdData, 32'h1);
        chk("repeated beats", {31'h0, (readCount - r0) > 16'h1}, 32'h1);
        // Channel off refuses to transfer
        run(32'h100, 32'h0, 16'h0100, 16'h1);
        repeat (20) @(posedge clk_sys);
        apb(1'b0, `OFF_BLOCK_COUNTER, 32'h0);
        chk("count while off", rdData, 32'h1);
        chk("reads while off", {16'h0, readCount - r0}, 32'h0);
        apb(1'b1, `OFF_CHANNEL_CONTROL, 32'h0);
        conclude();
    end

    // Watchdog well beyond the expected few hundred cycles
    initial begin
        #200us;
        errCount++;
        conclude();
    end
endmodule : tb

// File: verilog/dma_addr_counter.sv
// Purpose: One address counter with software load and step update
// Assumes: Load from software has priority over a step in the same cycle
// Notes: Steps by one or two, up or down, as the step code says
`timescale 1ns/10ps
`include "dma_channel_defs.svh"
module dma_addr_counter
    import dma_channel_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire logic load,
    input wire logic [`ADDR_WIDTH-1:0] loadData,
    input wire logic stepFire,
    input wire logic stepEnable,
    input wire step_code_t stepCode,
    output logic [`ADDR_WIDTH-1:0] count
);

    logic [`ADDR_WIDTH-1:0] count_reg;
    logic [`ADDR_WIDTH-1:0] count_next;
    logic [`ADDR_WIDTH-1:0] stepped;

    // ============================================================
    // Step selection: +1, +2, -1, -2
    assign stepped = (stepCode == STEP_INC1) ? count_reg + 32'h00000001 :
                     (stepCode == STEP_INC2) ? count_reg + 32'h00000002 :
                     (stepCode == STEP_DEC1) ? count_reg - 32'h00000001 :
                     count_reg - 32'h00000002;

    // Counter holds unless loaded, or enabled and a transfer cycle completed
    assign count_next = load ? loadData :
                        (stepFire && stepEnable) ? stepped : count_reg;

    // ============================================================
    // Counter register
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            count_reg <= `ADDR_RESET;
        end else begin
            count_reg <= count_next;
        end
    end

    assign count = count_reg;

endmodule : dma_addr_counter

// File: verilog/dma_channel_control.sv
// Purpose: Control field logic and transfer sequencer of one DMA channel
// Assumes: APB slave; bus grant and memory done come from clk_sys logic
// Notes: Fly-by does one access at side A; indirect reads then writes
//
// Notes on behaviour
// - Transfer type 0 does fly-by transfers, 1 memory-to-memory; fly-by default.
// - Direction 0 makes side A the source; fly-by then reads.
// - Direction 1 makes side A the destination; fly-by then writes.
// - Repeat mode 0 single/double buffer (default), 1 auto-initialize.
// - Hold policy 0 releases the bus after every transaction.
// - Hold policy 1 keeps the bus while the request stays asserted.
// - Soft request bit 8 raises a request while it holds one.
// - Side A enable 0 freezes the side A counter, 1 lets it step.
// - Side A code: 00 +1, 01 +2, 10 -1, 11 -2.
// - Side B enable 0 freezes the side B counter, 1 lets it step.
// - Side B code: 00 +1, 01 +2, 10 -1, 11 -2.
// - Beat size 0 moves bytes, 1 moves 16-bit words.
// - Channel on must be 1 to operate; cleared, the clock gates off.
//
// Decided for this implementation: the APB interface to the registers and the register offsets.
`timescale 1ns/10ps
`include "dma_channel_defs.svh"
module dma_channel_control
    import dma_channel_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst_b,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Hardware request pin and acknowledge
    input wire logic hwRequest,
    output logic flyByAck,
    // Internal bus master
    output logic busRequest,
    input wire logic busGrant,
    output logic [31:0] memAddr,
    output logic memRead,
    output logic memWrite,
    output logic memWordSize,
    output logic [15:0] memWdata,
    input wire logic [15:0] memRdata,
    input wire logic memDone,
    // Clock gating request
    output logic channelClockOn
);

    // ============================================================
    // Declarations
    logic [`CONTROL_WIDTH-1:0] control_reg;
    logic [`CONTROL_WIDTH-1:0] control_next;
    logic [`COUNT_WIDTH-1:0] blockCount_reg;
    logic [`COUNT_WIDTH-1:0] blockCount_next;
    logic [`COUNT_WIDTH-1:0] blockStart_reg;
    logic [`ADDR_WIDTH-1:0] startA_reg;
    logic [`ADDR_WIDTH-1:0] startB_reg;
    logic [15:0] holdData_reg;
    logic [31:0] prdata_reg;
    seq_state_t state_reg;
    seq_state_t state_next;
    logic [`ADDR_WIDTH-1:0] countA;
    logic [`ADDR_WIDTH-1:0] countB;
    logic hwRequestSync;

    // ============================================================
    // Control fields
    wire channelOn = control_reg[`BIT_CHANNEL_ON];
    wire beatSizeSelect = control_reg[`BIT_BEAT_SIZE];
    wire transferTypeSelect = control_reg[`BIT_TRANSFER_TYPE];
    wire directionSelect = control_reg[`BIT_DIRECTION];
    wire repeatModeSelect = control_reg[`BIT_REPEAT_MODE];
    wire busHoldPolicy = control_reg[`BIT_BUS_HOLD];
    wire softRequest = control_reg[`BIT_SOFT_REQUEST];
    wire sideAStepEnable = control_reg[`BIT_A_STEP_ENABLE];
    wire sideBStepEnable = control_reg[`BIT_B_STEP_ENABLE];
    wire step_code_t sideAStepCode = step_code_t'(control_reg[`POS_A_STEP_CODE +: 2]);
    wire step_code_t sideBStepCode = step_code_t'(control_reg[`POS_B_STEP_CODE +: 2]);

    // ============================================================
    // APB address decode
    wire selA = (paddr == `OFF_SIDE_A_COUNTER);
    wire selB = (paddr == `OFF_SIDE_B_COUNTER);
    wire selCount = (paddr == `OFF_BLOCK_COUNTER);
    wire selControl = (paddr == `OFF_CHANNEL_CONTROL);
    wire selStatus = (paddr == `OFF_CHANNEL_STATUS);
    wire selAny = selA || selB || selCount || selControl || selStatus;
    wire apbSetup = psel && !penable;
    wire apbWrite = psel && penable && pwrite && selAny;
    wire writeA = apbWrite && selA;
    wire writeB = apbWrite && selB;
    wire writeCount = apbWrite && selCount;
    wire writeControl = apbWrite && selControl;

    // ============================================================
    // Request and activity
    wire channelRequest = softRequest || hwRequestSync;
    wire channelActive = channelOn && (blockCount_reg != `COUNT_RESET);
    wire canTransfer = channelActive && channelRequest;
    wire indirectMode = transferTypeSelect;

    // Completion of the last access of one transfer cycle
    wire flyDone = !indirectMode && memDone &&
                   (state_reg == ST_READ || state_reg == ST_WRITE);
    wire indirectDone = indirectMode && memDone && (state_reg == ST_WRITE);
    wire cycleDone = flyDone || indirectDone;
    wire lastBeat = (blockCount_reg == 16'h0001);
    wire reloadBlock = cycleDone && lastBeat && repeatModeSelect;

    // Keep the bus only under hold policy with a live request and count left
    wire holdBus = busHoldPolicy && canTransfer;
    // A reloaded count in auto-initialize keeps channelActive high; canTransfer still needs the request

    // ============================================================
    // Input synchroniser for the hardware request pin
    dma_request_sync u_request_sync (
        .clk_sys(clk_sys),
        .rst_b(rst_b),
        .pinIn(hwRequest),
        .syncOut(hwRequestSync)
    );

    // ============================================================
    // Side A counter; reload from start value in auto-initialize
    dma_addr_counter u_side_a_address_counter (
        .clk_sys(clk_sys),
        .rst_b(rst_b),
        .load(writeA || reloadBlock),
        .loadData(writeA ? pwdata : startA_reg),
        .stepFire(cycleDone),
        .stepEnable(sideAStepEnable),
        .stepCode(sideAStepCode),
        .count(countA)
    );

    // Side B counter steps only in indirect mode
    dma_addr_counter u_side_b_address_counter (
        .clk_sys(clk_sys),
        .rst_b(rst_b),
        .load(writeB || reloadBlock),
        .loadData(writeB ? pwdata : startB_reg),
        .stepFire(indirectDone),
        .stepEnable(sideBStepEnable),
        .stepCode(sideBStepCode),
        .count(countB)
    );

    // ============================================================
    // Control register next value; reserved bit 15 stays zero
    assign control_next = writeControl ? (pwdata[15:0] & `CONTROL_WRITE_MASK) : control_reg;

    // Block counter: load, decrement per cycle, reload in auto-initialize
    assign blockCount_next = writeCount ? pwdata[15:0] :
                             reloadBlock ? blockStart_reg :
                             cycleDone ? blockCount_reg - 16'h0001 :
                             blockCount_reg;

    // ============================================================
    // Sequencer next state
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            ST_IDLE: begin
                if (canTransfer) begin
                    state_next = ST_ARBITRATE;
                end
            end
            ST_ARBITRATE: begin
                if (!canTransfer) begin
                    state_next = ST_IDLE;
                end else if (busGrant) begin
                    if (indirectMode || !directionSelect) begin
                        state_next = ST_READ;
                    end else begin
                        state_next = ST_WRITE;
                    end
                end
            end
            ST_READ: begin
                if (memDone && indirectMode) begin
                    state_next = ST_WRITE;
                end else if (memDone) begin
                    state_next = ST_RELEASE;
                end
            end
            ST_WRITE: begin
                if (memDone) begin
                    state_next = ST_RELEASE;
                end
            end
            ST_RELEASE: begin
                if (holdBus) begin
                    // Burst: next transaction without giving up the bus
                    if (indirectMode || !directionSelect) begin
                        state_next = ST_READ;
                    end else begin
                        state_next = ST_WRITE;
                    end
                end else begin
                    state_next = ST_IDLE;
                end
            end
            default: begin
                state_next = ST_IDLE;
            end
        endcase
    end

    // ============================================================
    // Bus outputs; request drops in release, also when holding
    wire inAccess = (state_reg == ST_READ) || (state_reg == ST_WRITE);
    assign busRequest = (state_reg == ST_ARBITRATE) || inAccess;
    assign memRead = (state_reg == ST_READ);
    assign memWrite = (state_reg == ST_WRITE);
    assign memWordSize = beatSizeSelect;
    // Indirect: read from the source side, write to the other side
    wire readFromA = !directionSelect;
    assign memAddr = !indirectMode ? countA :
                     (memRead == readFromA) ? countA : countB;
    assign memWdata = beatSizeSelect ? holdData_reg : {8'h00, holdData_reg[7:0]};
    assign flyByAck = !indirectMode && inAccess;
    assign channelClockOn = channelOn;

    // ============================================================
    // Read data mux and status word
    wire [31:0] statusWord = {29'h00000000, channelRequest,
                              (state_reg != ST_IDLE && state_reg != ST_ARBITRATE),
                              channelActive};
    wire [31:0] readMux = selA ? countA :
                          selB ? countB :
                          selCount ? {16'h0000, blockCount_reg} :
                          selControl ? {16'h0000, control_reg} :
                          selStatus ? statusWord : 32'h00000000;

    assign prdata = prdata_reg;
    assign pready = 1'b1;
    assign pslverr = psel && penable && !selAny;

    // ============================================================
    // Control and block counters
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            control_reg <= `CONTROL_RESET;
            blockCount_reg <= `COUNT_RESET;
        end else begin
            control_reg <= control_next;
            blockCount_reg <= blockCount_next;
        end
    end

    // ============================================================
    // Start values kept for auto-initialize reload
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            startA_reg <= `ADDR_RESET;
            startB_reg <= `ADDR_RESET;
            blockStart_reg <= `COUNT_RESET;
        end else begin
            startA_reg <= writeA ? pwdata : startA_reg;
            startB_reg <= writeB ? pwdata : startB_reg;
            blockStart_reg <= writeCount ? pwdata[15:0] : blockStart_reg;
        end
    end

    // ============================================================
    // Sequencer state and indirect holding data
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            state_reg <= ST_IDLE;
            holdData_reg <= 16'h0000;
        end else begin
            state_reg <= state_next;
            if (memRead && memDone && indirectMode) begin
                holdData_reg <= memRdata;
            end
        end
    end

    // ============================================================
    // Read data registered in the setup phase
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            prdata_reg <= 32'h00000000;
        end else if (apbSetup && !pwrite) begin
            prdata_reg <= readMux;
        end
    end

endmodule : dma_channel_control

// File: verilog/dma_request_sync.sv
// Purpose: Two-flop synchroniser for the hardware request pin
// Assumes: Pin is asynchronous to clk_sys
// Notes: Only the second stage is visible outside
`timescale 1ns/10ps
module dma_request_sync (
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire logic pinIn,
    output logic syncOut
);

    logic stageOne_reg;
    logic stageTwo_reg;

    // ============================================================
    // Two stages, first read only by the second
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            stageOne_reg <= 1'b0;
            stageTwo_reg <= 1'b0;
        end else begin
            stageOne_reg <= pinIn;
            stageTwo_reg <= stageOne_reg;
        end
    end

    assign syncOut = stageTwo_reg;

endmodule : dma_request_sync
